//--- shs_regs.sv
// Function
// [RQ1] Command register sent as command byte
// [RQ2] Address bits 7:1 form target address
// [RQ3] Address bit 0: one reads, zero writes
// [RQ4] First data sent on write, stored on read
// [RQ5] Block write loads first data as count
// [RQ6] Software keeps block count within 1..32
// [RQ7] Block read stores received count in first data
// [RQ8] Second data sent on write, stored on read
// [RQ9] Block port accesses array byte at pointer
// [RQ10] Reading host control clears block pointer
// [RQ11] Each block port access advances pointer
// [RQ12] Bus block transfers start at location zero
// [RQ13] Alert enable gates alert-driven events
// [RQ14] Second mirror address match raises event
// [RQ15] First mirror address match raises event
// [RQ16] Slave port event needs address, command, data
// [RQ17] Capture command from port or mirror hits
// [RQ18] Start writes launch command, read zero
// [RQ19] Protocol field picks host command type
// [RQ20] Event mask bit with data bit triggers
// [RQ21] Reserved enable bits read zero, ignore writes
// [RQ22] Array stays stable after block transfer
`timescale 1ns/1ps
`default_nettype none
module shs_regs (
    // System
    input wire logic mclk,
    input wire logic rstn,
    // Software I/O port
    input wire logic [3:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    // Slave configuration from the parent controller
    input wire logic [6:0] first_mirror_address,
    input wire logic [6:0] second_mirror_address,
    input wire logic [7:0] slave_command_match,
    input wire logic [15:0] slave_event_mask,
    // Host engine view
    output logic host_busy,
    output shs_pkg::shs_params_type host_params,
    // Slave events
    input wire logic smb_alert_n,
    output logic event_pulse,
    output logic [3:0] event_source,
    output logic [15:0] slave_received_data,
    // Link engine, on its own clock
    input wire logic link_clk,
    output logic lx_start,
    input wire logic lx_req,
    input wire shs_pkg::shs_op_type lx_op,
    input wire logic [6:0] lx_addr,
    input wire logic [7:0] lx_cmd,
    input wire logic [15:0] lx_data,
    output logic lx_ready,
    output logic [7:0] lx_rdata
);
    // Core domain state
    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] addr;
        logic [7:0] d0;
        logic [7:0] d1;
        logic [2:0] prot;
        logic [3:0] slvcnt;
        logic [7:0] shadow;
        logic [15:0] sdata;
        logic [4:0] sw_ptr;
        logic [4:0] xf_ptr;
        logic [7:0] blk_cnt;
        logic [shs_pkg::BLOCK_DEPTH-1:0][7:0] arr;
        shs_pkg::shs_hstate_type hstate;
        logic start_tog;
        logic ack_tog;
        logic req_s1;
        logic req_s2;
        logic req_s3;
        logic alert_s1;
        logic alert_s2;
        logic alert_s3;
        logic [7:0] rdata;
        logic [7:0] resp;
        logic ev;
        logic [3:0] evsrc;
    } shs_core_type;

    // Link domain state
    typedef struct packed {
        logic st_s1;
        logic st_s2;
        logic st_s3;
        logic req_tog;
        logic ack_s1;
        logic ack_s2;
        logic ack_s3;
        shs_pkg::shs_op_type op;
        logic [6:0] addr;
        logic [7:0] cmd;
        logic [15:0] data;
        logic [7:0] rdata;
    } shs_link_type;

    shs_core_type q; // Core registers
    shs_core_type d; // Core next value
    shs_link_type lq; // Link registers
    shs_link_type ld; // Link next value
    logic take; // Link request seen in core domain
    logic hit_port; // Slave port address hit
    logic hit_m1; // First mirror hit
    logic hit_m2; // Second mirror hit

    // Core next-state logic
    always_comb begin
        d = q;
        d.ev = 1'b0;
        d.evsrc = 4'h0;
        // Two-flop synchronisers plus edge history
        d.alert_s1 = smb_alert_n;
        d.alert_s2 = q.alert_s1;
        d.alert_s3 = q.alert_s2;
        d.req_s1 = lq.req_tog;
        d.req_s2 = q.req_s1;
        d.req_s3 = q.req_s2;
        take = q.req_s2 ^ q.req_s3;
        hit_port = lq.addr == shs_pkg::SLAVE_PORT_ADDR;
        hit_m1 = lq.addr == first_mirror_address;
        hit_m2 = lq.addr == second_mirror_address;
        // Software writes
        if (io_wr) begin
            case (io_addr)
                shs_pkg::OFS_HOST_CMD: begin
                    d.cmd = io_wdata; // RQ1
                end
                shs_pkg::OFS_HOST_ADDR: begin
                    d.addr = io_wdata; // RQ2
                end
                shs_pkg::OFS_DATA_FIRST: begin
                    d.d0 = io_wdata; // RQ4
                end
                shs_pkg::OFS_DATA_SECOND: begin
                    d.d1 = io_wdata; // RQ8
                end
                shs_pkg::OFS_HOST_CTRL: begin
                    // Protocol select
                    d.prot = io_wdata[shs_pkg::CTRL_PROT_LSB +: 3]; // RQ19
                    // Start ignored while a command runs
                    if (io_wdata[shs_pkg::CTRL_START_BIT] &&
                        q.hstate == shs_pkg::HS_IDLE) begin
                        d.hstate = shs_pkg::HS_BUSY; // RQ18
                        d.start_tog = ~q.start_tog;
                        d.xf_ptr = 5'h00; // RQ12
                        d.blk_cnt = q.d0; // RQ5 RQ6
                    end
                end
                shs_pkg::OFS_BLOCK_PORT: begin
                    d.arr[q.sw_ptr] = io_wdata; // RQ9
                    d.sw_ptr = q.sw_ptr + 5'h01; // RQ11
                end
                shs_pkg::OFS_SLAVE_ENABLES: begin
                    d.slvcnt = io_wdata[3:0]; // RQ21
                end
                default: begin
                    // Unmapped or read-only: ignored
                end
            endcase
        end
        // Software reads, answered one cycle later
        if (io_rd) begin
            case (io_addr)
                shs_pkg::OFS_HOST_CTRL: begin
                    // Start reads zero
                    d.rdata = {3'h0, q.prot, 2'h0}; // RQ18
                    d.sw_ptr = 5'h00; // RQ10
                end
                shs_pkg::OFS_HOST_CMD: begin
                    d.rdata = q.cmd;
                end
                shs_pkg::OFS_HOST_ADDR: begin
                    d.rdata = q.addr;
                end
                shs_pkg::OFS_DATA_FIRST: begin
                    d.rdata = q.d0;
                end
                shs_pkg::OFS_DATA_SECOND: begin
                    d.rdata = q.d1;
                end
                shs_pkg::OFS_BLOCK_PORT: begin
                    d.rdata = q.arr[q.sw_ptr]; // RQ9
                    d.sw_ptr = q.sw_ptr + 5'h01; // RQ11
                end
                shs_pkg::OFS_SLAVE_ENABLES: begin
                    d.rdata = {4'h0, q.slvcnt}; // RQ21
                end
                shs_pkg::OFS_CMD_CAPTURE: begin
                    d.rdata = q.shadow;
                end
                default: begin
                    d.rdata = shs_pkg::RST_BYTE;
                end
            endcase
        end
        // Link engine requests; held fields are stable here
        if (take) begin
            d.ack_tog = ~q.ack_tog;
            case (lq.op)
                shs_pkg::OP_RX_FIRST: begin
                    d.d0 = lq.data[7:0]; // RQ4
                end
                shs_pkg::OP_RX_SECOND: begin
                    d.d1 = lq.data[7:0]; // RQ8
                end
                shs_pkg::OP_RX_COUNT: begin
                    d.d0 = lq.data[7:0]; // RQ7
                end
                shs_pkg::OP_RX_BLOCK: begin
                    d.arr[q.xf_ptr] = lq.data[7:0]; // RQ12
                    d.xf_ptr = q.xf_ptr + 5'h01;
                end
                shs_pkg::OP_TX_BLOCK: begin
                    d.resp = q.arr[q.xf_ptr]; // RQ12
                    d.xf_ptr = q.xf_ptr + 5'h01;
                end
                shs_pkg::OP_DONE: begin
                    // Array left untouched at the end
                    d.hstate = shs_pkg::HS_IDLE; // RQ22
                end
                shs_pkg::OP_SLAVE: begin
                    if (hit_port || hit_m1 || hit_m2) begin
                        d.shadow = lq.cmd; // RQ17
                        d.sdata = lq.data;
                    end
                    d.evsrc[0] = q.slvcnt[shs_pkg::EN_SLAVE_PORT_BIT] &&
                        hit_port && lq.cmd == slave_command_match &&
                        (|(slave_event_mask & lq.data)); // RQ16 RQ20
                    d.evsrc[1] = q.slvcnt[shs_pkg::EN_MIRROR1_BIT] &&
                        hit_m1; // RQ15
                    d.evsrc[2] = q.slvcnt[shs_pkg::EN_MIRROR2_BIT] &&
                        hit_m2; // RQ14
                end
                default: begin
                    // Unknown request only acknowledged
                end
            endcase
        end
        // Alert assertion is a falling edge
        d.evsrc[3] = q.slvcnt[shs_pkg::EN_ALERT_BIT] &&
            q.alert_s3 && !q.alert_s2; // RQ13
        d.ev = |d.evsrc;
    end

    // Core registers
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
            q.hstate <= shs_pkg::HS_IDLE;
            q.alert_s1 <= 1'b1;
            q.alert_s2 <= 1'b1;
            q.alert_s3 <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Link next-state logic
    always_comb begin
        ld = lq;
        ld.st_s1 = q.start_tog;
        ld.st_s2 = lq.st_s1;
        ld.st_s3 = lq.st_s2;
        ld.ack_s1 = q.ack_tog;
        ld.ack_s2 = lq.ack_s1;
        ld.ack_s3 = lq.ack_s2;
        // Hold request fields until acknowledged
        if (lx_req && lx_ready) begin
            ld.req_tog = ~lq.req_tog;
            ld.op = lx_op;
            ld.addr = lx_addr;
            ld.cmd = lx_cmd;
            ld.data = lx_data;
        end
        // Answer byte is stable once the ack toggles
        if (lq.ack_s2 != lq.ack_s3) begin
            ld.rdata = q.resp;
        end
    end

    // Link registers
    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            lq <= '0;
            lq.op <= shs_pkg::OP_DONE;
        end else begin
            lq <= ld;
        end
    end

    // Outputs
    assign io_rdata = q.rdata;
    assign host_busy = q.hstate == shs_pkg::HS_BUSY;
    assign host_params.command_field_value = q.cmd; // RQ1
    assign host_params.target_slave_addr = q.addr[7:1]; // RQ2
    assign host_params.direction_select = q.addr[0]; // RQ3
    assign host_params.first_data_value = q.d0; // RQ4
    assign host_params.second_data_value = q.d1; // RQ8
    assign host_params.protocol_select = q.prot; // RQ19
    assign host_params.block_count = q.blk_cnt; // RQ5
    assign event_pulse = q.ev;
    assign event_source = q.evsrc;
    assign slave_received_data = q.sdata;
    assign lx_start = lq.st_s2 ^ lq.st_s3;
    assign lx_ready = lq.req_tog == lq.ack_s3;
    assign lx_rdata = lq.rdata;

    // Named steps
    sequence seq_ctrl_read;
        io_rd && io_addr == shs_pkg::OFS_HOST_CTRL && !io_wr;
    endsequence
    sequence seq_start_write;
        io_wr && io_addr == shs_pkg::OFS_HOST_CTRL &&
            io_wdata[shs_pkg::CTRL_START_BIT] && !host_busy;
    endsequence
    sequence seq_block_access;
        (io_wr ^ io_rd) && io_addr == shs_pkg::OFS_BLOCK_PORT;
    endsequence

    a_ctrl_clears_ptr: assert property ( // RQ10
        @(posedge mclk) disable iff (!rstn)
        seq_ctrl_read |=> q.sw_ptr == 5'h00)
        else $error("Control read left block pointer nonzero");
    a_start_reads_zero: assert property ( // RQ18
        @(posedge mclk) disable iff (!rstn)
        seq_ctrl_read |=> io_rdata[shs_pkg::CTRL_START_BIT] == 1'b0)
        else $error("Start bit read back as one");
    a_block_ptr_step: assert property ( // RQ11
        @(posedge mclk) disable iff (!rstn)
        seq_block_access |=> q.sw_ptr == $past(q.sw_ptr) + 5'h01)
        else $error("Block pointer did not advance by one");
    a_start_loads_count: assert property ( // RQ5
        @(posedge mclk) disable iff (!rstn)
        seq_start_write |=> host_busy && q.xf_ptr == 5'h00 &&
            host_params.block_count == $past(q.d0))
        else $error("Start did not load count or clear transfer index");
    a_start_reaches_link: assert property ( // RQ18
        @(posedge mclk) disable iff (!rstn)
        seq_start_write |=> q.start_tog != $past(q.start_tog))
        else $error("Start did not signal the link engine");
    a_alert_gated: assert property ( // RQ13
        @(posedge mclk) disable iff (!rstn)
        $fell(q.alert_s2) |=>
            event_source[3] == $past(q.slvcnt[shs_pkg::EN_ALERT_BIT]))
        else $error("Alert event not gated by its enable");
    a_reserved_zero: assert property ( // RQ21
        @(posedge mclk) disable iff (!rstn)
        io_rd && io_addr == shs_pkg::OFS_SLAVE_ENABLES |=>
            io_rdata[7:4] == 4'h0)
        else $error("Reserved enable bits read nonzero");
    a_capture_command: assert property ( // RQ17
        @(posedge mclk) disable iff (!rstn)
        take && lq.op == shs_pkg::OP_SLAVE &&
            (hit_port || hit_m1 || hit_m2) |=>
            q.shadow == $past(lq.cmd) &&
            slave_received_data == $past(lq.data))
        else $error("Slave command not captured");
    a_mirror_event: assert property ( // RQ15
        @(posedge mclk) disable iff (!rstn)
        take && lq.op == shs_pkg::OP_SLAVE && hit_m1 &&
            q.slvcnt[shs_pkg::EN_MIRROR1_BIT] |=>
            event_pulse && event_source[1])
        else $error("First mirror hit raised no event");
    a_mirror2_event: assert property ( // RQ14
        @(posedge mclk) disable iff (!rstn)
        take && lq.op == shs_pkg::OP_SLAVE && hit_m2 &&
            q.slvcnt[shs_pkg::EN_MIRROR2_BIT] |=>
            event_pulse && event_source[2])
        else $error("Second mirror hit raised no event");
    // Received count lands in the first data register
    a_count_stored: assert property ( // RQ7
        @(posedge mclk) disable iff (!rstn)
        take && lq.op == shs_pkg::OP_RX_COUNT |=>
            host_params.first_data_value == $past(lq.data[7:0]))
        else $error("Received block count not stored");
    // Each received block byte moves the transfer index on
    a_rx_index_step: assert property ( // RQ12
        @(posedge mclk) disable iff (!rstn)
        take && lq.op == shs_pkg::OP_RX_BLOCK |=>
            q.xf_ptr == $past(q.xf_ptr) + 5'h01)
        else $error("Block receive index did not advance");
endmodule : shs_regs
`default_nettype wire

//--- shs_pkg.sv
`default_nettype none
package shs_pkg;
    // Register offsets on the I/O port
    localparam logic [3:0] OFS_HOST_CTRL = 4'h2;
    localparam logic [3:0] OFS_HOST_CMD = 4'h3;
    localparam logic [3:0] OFS_HOST_ADDR = 4'h4;
    localparam logic [3:0] OFS_DATA_FIRST = 4'h5;
    localparam logic [3:0] OFS_DATA_SECOND = 4'h6;
    localparam logic [3:0] OFS_BLOCK_PORT = 4'h7;
    localparam logic [3:0] OFS_SLAVE_ENABLES = 4'h8;
    localparam logic [3:0] OFS_CMD_CAPTURE = 4'h9;
    // Field positions
    localparam int CTRL_START_BIT = 6;
    localparam int CTRL_PROT_LSB = 2;
    localparam int EN_ALERT_BIT = 3;
    localparam int EN_MIRROR2_BIT = 2;
    localparam int EN_MIRROR1_BIT = 1;
    localparam int EN_SLAVE_PORT_BIT = 0;
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    // Fixed slave port address
    localparam logic [6:0] SLAVE_PORT_ADDR = 7'h10;
    // Block storage depth
    localparam int BLOCK_DEPTH = 32;
    // Host command protocols
    typedef enum logic [2:0] {
        PROT_QUICK = 3'h0,
        PROT_BYTE = 3'h1,
        PROT_BYTE_DATA = 3'h2,
        PROT_WORD_DATA = 3'h3
    } shs_prot_type;
    // Requests from the link engine
    typedef enum logic [2:0] {
        OP_RX_FIRST = 3'h0,
        OP_RX_SECOND = 3'h1,
        OP_RX_COUNT = 3'h2,
        OP_RX_BLOCK = 3'h3,
        OP_TX_BLOCK = 3'h4,
        OP_DONE = 3'h5,
        OP_SLAVE = 3'h6
    } shs_op_type;
    // Host engine states
    typedef enum logic [1:0] {
        HS_IDLE = 2'b01,
        HS_BUSY = 2'b10
    } shs_hstate_type;
    // Host transaction fields handed to the link engine
    typedef struct packed {
        logic [7:0] command_field_value;
        logic [6:0] target_slave_addr;
        logic direction_select;
        logic [7:0] first_data_value;
        logic [7:0] second_data_value;
        logic [2:0] protocol_select;
        logic [7:0] block_count;
    } shs_params_type;
endpackage : shs_pkg
`default_nettype wire

//--- shs_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module shs_link_model (
    // Link side of the block
    input wire logic link_clk,
    input wire logic lx_start,
    input wire logic lx_ready,
    input wire logic [7:0] lx_rdata,
    output logic lx_req,
    output shs_pkg::shs_op_type lx_op,
    output logic [6:0] lx_addr,
    output logic [7:0] lx_cmd,
    output logic [15:0] lx_data,
    // Start pulses seen so far
    output logic [7:0] n_start
);
    // Idle levels at time zero
    initial begin
        lx_req = 1'b0;
        lx_op = shs_pkg::OP_DONE;
        lx_addr = 7'h2a;
        lx_cmd = 8'h55;
        lx_data = 16'haaaa;
        n_start = 8'h00;
    end
    // Count each new host command
    always @(posedge link_clk) begin
        if (lx_start === 1'b1) begin
            n_start <= n_start + 8'h01;
        end
    end
    // One request, held until taken, then wait for the answer
    task automatic send(input shs_pkg::shs_op_type o, input logic [6:0] a,
            input logic [7:0] c, input logic [15:0] d,
            output logic [7:0] r);
        int n;
        @(posedge link_clk);
        #1;
        lx_req = 1'b1;
        lx_op = o;
        lx_addr = a;
        lx_cmd = c;
        lx_data = d;
        do @(posedge link_clk); while (lx_ready !== 1'b1);
        #1;
        lx_req = 1'b0;
        // Released fields must not keep showing the old value
        lx_addr = ~lx_addr;
        lx_cmd = ~lx_cmd;
        lx_data = ~lx_data;
        n = 0;
        while (lx_ready === 1'b1 && n < 4) begin
            @(posedge link_clk);
            #1;
            n++;
        end
        n = 0;
        while (lx_ready !== 1'b1 && n < 40) begin
            @(posedge link_clk);
            #1;
            n++;
        end
        r = lx_rdata;
    endtask : send
endmodule : shs_link_model
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_mismatch++; \
    $display("wrong value t=%0t got %h exp %h", $time, a, e); end end
module testbench;
    // Clocks, reset and bus
    logic mclk = 1'b0;
    logic link_clk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] io_addr = 4'h0;
    logic io_wr = 1'b0;
    logic io_rd = 1'b0;
    logic [7:0] io_wdata = 8'h00;
    logic [7:0] io_rdata;
    // Slave setup and events
    logic [6:0] mir1 = 7'h21;
    logic [6:0] mir2 = 7'h32;
    logic [7:0] cmd_match = 8'h5e;
    logic [15:0] ev_mask = 16'h0100;
    logic smb_alert_n = 1'b1;
    logic host_busy, event_pulse, lx_start, lx_req, lx_ready;
    logic [3:0] event_source;
    logic [3:0] ev_seen = 4'h0;
    logic ev_clr = 1'b0;
    logic [15:0] slave_received_data, lx_data;
    shs_pkg::shs_params_type host_params;
    shs_pkg::shs_op_type lx_op;
    logic [6:0] lx_addr;
    logic [7:0] lx_cmd, lx_rdata, n_start, r;
    int n_tests = 0;
    int n_mismatch = 0;
    // Clocks, unrelated in phase
    always #4 mclk = ~mclk;
    always #15 link_clk = ~link_clk;
    // Gather event sources
    always @(posedge mclk) begin
        if (ev_clr) begin
            ev_seen <= 4'h0;
        end else if (event_pulse === 1'b1) begin
            ev_seen <= ev_seen | event_source;
        end
    end
    shs_regs dut_u (.mclk(mclk), .rstn(rstn), .io_addr(io_addr),
        .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .first_mirror_address(mir1),
        .second_mirror_address(mir2), .slave_command_match(cmd_match),
        .slave_event_mask(ev_mask), .host_busy(host_busy),
        .host_params(host_params), .smb_alert_n(smb_alert_n),
        .event_pulse(event_pulse), .event_source(event_source),
        .slave_received_data(slave_received_data), .link_clk(link_clk),
        .lx_start(lx_start), .lx_req(lx_req), .lx_op(lx_op),
        .lx_addr(lx_addr), .lx_cmd(lx_cmd), .lx_data(lx_data),
        .lx_ready(lx_ready), .lx_rdata(lx_rdata));
    shs_link_model lnk (.link_clk(link_clk), .lx_start(lx_start),
        .lx_ready(lx_ready), .lx_rdata(lx_rdata), .lx_req(lx_req),
        .lx_op(lx_op), .lx_addr(lx_addr), .lx_cmd(lx_cmd),
        .lx_data(lx_data), .n_start(n_start));
    // Register write, one strobe cycle
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge mclk);
        io_wr = 1'b1;
        io_addr = a;
        io_wdata = d;
        @(negedge mclk);
        io_wr = 1'b0;
    endtask : wr
    // Register read and compare
    task automatic rchk(input logic [3:0] a, input logic [7:0] e);
        @(negedge mclk);
        io_rd = 1'b1;
        io_addr = a;
        @(negedge mclk);
        io_rd = 1'b0;
        @(negedge mclk);
        `CHK(io_rdata, e)
    endtask : rchk
    // Write start and wait for the link to see it
    task automatic start(input logic [7:0] ctl);
        logic [7:0] s0;
        int n;
        s0 = n_start;
        wr(4'h2, ctl);
        n = 0;
        while (n_start === s0 && n < 60) begin
            @(negedge mclk);
            n++;
        end
        `CHK(n_start, s0 + 8'h01)
        `CHK(host_busy, 1'b1)
    endtask : start
    // Finish a host command and check idle
    task automatic finish_cmd;
        lnk.send(shs_pkg::OP_DONE, 7'h00, 8'h00, 16'h0000, r);
        repeat (3) @(negedge mclk);
        `CHK(host_busy, 1'b0)
    endtask : finish_cmd
    // Clear the gathered event sources at the next clock edge
    task automatic clr_ev;
        ev_clr = 1'b1;
        @(negedge mclk);
        ev_clr = 1'b0;
    endtask : clr_ev
    // Slave transaction and its event sources
    task automatic slv(input logic [6:0] a, input logic [7:0] c,
            input logic [15:0] d, input logic [3:0] e);
        clr_ev();
        lnk.send(shs_pkg::OP_SLAVE, a, c, d, r);
        repeat (6) @(negedge mclk);
        `CHK(ev_seen, e)
    endtask : slv
    // Reset values and unmapped read
    task automatic t_reset;
        for (int a = 2; a < 10; a++) rchk(4'(a), 8'h00);
        rchk(4'hf, 8'h00);
        $display("test reset done");
    endtask : t_reset
    // Host fields reach the engine, reserved bits, read-only capture
    task automatic t_regs;
        logic [7:0] e[4] = '{8'h96, 8'hb5, 8'h3c, 8'hc3};
        for (int i = 0; i < 4; i++) wr(4'(3 + i), e[i]);
        for (int i = 0; i < 4; i++) rchk(4'(3 + i), e[i]);
        `CHK(host_params.command_field_value, 8'h96)
        `CHK(host_params.target_slave_addr, 7'h5a)
        `CHK(host_params.direction_select, 1'b1)
        `CHK(host_params.first_data_value, 8'h3c)
        `CHK(host_params.second_data_value, 8'hc3)
        wr(4'h4, 8'hb4);
        `CHK(host_params.direction_select, 1'b0)
        wr(4'h8, 8'hff);
        rchk(4'h8, 8'h0f);
        wr(4'h9, 8'h77);
        rchk(4'h9, 8'h00);
        $display("test regs done");
    endtask : t_regs
    // Block array through the auto-incrementing pointer
    task automatic t_block;
        rchk(4'h2, 8'h00);
        for (int i = 0; i < 32; i++) wr(4'h7, 8'(i) ^ 8'ha5);
        rchk(4'h2, 8'h00);
        for (int i = 0; i < 5; i++) rchk(4'h7, 8'(i) ^ 8'ha5);
        rchk(4'h2, 8'h00);
        for (int i = 0; i < 32; i++) rchk(4'h7, 8'(i) ^ 8'ha5);
        $display("test block done");
    endtask : t_block
    // Host write commands of every protocol
    task automatic t_host_tx;
        wr(4'h5, 8'h03);
        wr(4'h4, 8'h60);
        for (int p = 0; p < 4; p++) begin
            start(8'h40 | 8'(p << 2));
            `CHK(host_params.protocol_select, 3'(p))
            `CHK(host_params.block_count, 8'h03)
            rchk(4'h2, 8'(p << 2));
            for (int i = 0; i < 3 && p == 3; i++) begin
                lnk.send(shs_pkg::OP_TX_BLOCK, 7'h00, 8'h00, 16'h0, r);
                `CHK(r, 8'(i) ^ 8'ha5)
            end
            finish_cmd();
        end
        $display("test host write done");
    endtask : t_host_tx
    // Host read stores bytes and block data
    task automatic t_host_rx;
        wr(4'h4, 8'h61);
        start(8'h48);
        lnk.send(shs_pkg::OP_RX_FIRST, 7'h00, 8'h00, 16'h0011, r);
        rchk(4'h5, 8'h11);
        lnk.send(shs_pkg::OP_RX_SECOND, 7'h00, 8'h00, 16'h0022, r);
        rchk(4'h6, 8'h22);
        lnk.send(shs_pkg::OP_RX_COUNT, 7'h00, 8'h00, 16'h0002, r);
        rchk(4'h5, 8'h02);
        lnk.send(shs_pkg::OP_RX_BLOCK, 7'h00, 8'h00, 16'h00c1, r);
        lnk.send(shs_pkg::OP_RX_BLOCK, 7'h00, 8'h00, 16'h00c2, r);
        finish_cmd();
        repeat (20) @(negedge mclk);
        rchk(4'h2, 8'h08);
        rchk(4'h7, 8'hc1);
        rchk(4'h7, 8'hc2);
        rchk(4'h7, 8'h02 ^ 8'ha5);
        $display("test host read done");
    endtask : t_host_rx
    // Slave and alert events with their enables
    task automatic t_events;
        wr(4'h8, 8'h0f);
        slv(7'h10, 8'h5e, 16'h0100, 4'h1);
        rchk(4'h9, 8'h5e);
        `CHK(slave_received_data, 16'h0100)
        slv(7'h10, 8'h5d, 16'h0100, 4'h0);
        slv(7'h10, 8'h5e, 16'h0200, 4'h0);
        slv(7'h21, 8'h44, 16'h0000, 4'h2);
        rchk(4'h9, 8'h44);
        slv(7'h32, 8'h45, 16'h0000, 4'h4);
        wr(4'h8, 8'h08);
        slv(7'h21, 8'h46, 16'h0000, 4'h0);
        slv(7'h32, 8'h47, 16'h0000, 4'h0);
        slv(7'h10, 8'h5e, 16'h0100, 4'h0);
        for (int k = 0; k < 2; k++) begin
            clr_ev();
            smb_alert_n = 1'b0;
            repeat (8) @(negedge mclk);
            `CHK(ev_seen, (k == 0) ? 4'h8 : 4'h0)
            smb_alert_n = 1'b1;
            wr(4'h8, 8'h00);
        end
        $display("test events done");
    endtask : t_events
    // Verdict and end of run
    task automatic tally_and_finish;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    // Watchdog against a hang
    initial begin
        #200000;
        n_mismatch++;
        tally_and_finish();
    end
    // Main sequence
    initial begin
        repeat (2) @(negedge mclk);
        rstn = 1'b1;
        t_reset();
        t_regs();
        t_block();
        t_host_tx();
        t_host_rx();
        t_events();
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
